// File: logic/rcs_consts.vh
// Holds the register selects, field positions and reset values of the
// reset-cause block. Included by the block's design file only.
`ifndef RCS_CONSTS_VH
`define RCS_CONSTS_VH

// ----------------------------------------------------------------------
// Register selects
// ----------------------------------------------------------------------
`define RCS_SEL_STATUS   1'b0
`define RCS_SEL_FORCE    1'b1

// ----------------------------------------------------------------------
// Field positions of the reset-cause status and force registers
// ----------------------------------------------------------------------
`define RCS_BIT_POWER_ON   7
`define RCS_BIT_PIN        6
`define RCS_BIT_WATCHDOG   5
`define RCS_BIT_ILL_OP     4
`define RCS_BIT_ILL_ADDR   3
`define RCS_BIT_CLK_GEN    2
`define RCS_BIT_LOW_VOLT   1
`define RCS_BIT_FORCE      0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RCS_STATUS_POR     8'h82
`define RCS_FORCE_READ     8'h00
`define RCS_WD_EN_RESET    1'b1

`endif

// File: logic/rcs_reset_cause.v
// Reset-cause status and debug force-reset logic.
// Assumes a reset controller outside that holds RST_N low for any system
// reset and shows which sources were active through the cause inputs,
// which stay valid while RST_N is low. POWER_ON_N is the raw power-on
// indication, low only while supply ramps.
//
// How it works
// - Cause flags are read-only to CPU writes.
// - Debug forced reset leaves all flags cleared.
// - Any status write restarts watchdog, flags kept.
// - Power-on sets bits 7 and 1 only.
// - Low-voltage reset keeps bit 7, sets bit 1.
// - Other resets latch active sources, rest zero.
// - Pin reset sets bit 6.
// - Watchdog timeout sets bit 5 when enabled.
// - Illegal opcode, unpermitted stop or background sets bit 4.
// - Illegal address access sets bit 3.
// - Clock generator request sets bit 2.
// - Low supply with both enables causes reset.
// - Force register reads zero, one bit.
// - CPU writes to force register ignored.
// - Debug write of one forces full reset.
// - Watchdog enable defaults one, zero disables.
`timescale 1ns/1ps
`include "rcs_consts.vh"

module rcs_reset_cause (
    CLK_SYS,
    RST_N,
    POWER_ON_N,
    CAUSE_PIN,
    CAUSE_WD_TIMEOUT,
    CAUSE_ILL_OP,
    CAUSE_STOP_EXEC,
    CAUSE_ENTER_BACKGROUND_INSTRUCTION_EXEC,
    CAUSE_ILL_ADDR,
    CAUSE_CLK_GEN,
    CAUSE_LOW_VOLT,
    STOP_PERMIT,
    BACKGROUND_PERMIT,
    WATCHDOG_ENABLE,
    LOW_VOLTAGE_RESET_ENABLE,
    LOW_VOLTAGE_STOP_ENABLE,
    REG_SEL,
    REG_WR,
    REG_RD,
    REG_DEBUG,
    REG_WDATA,
    REG_RDATA,
    WD_RESTART,
    RESET_REQ,
    RESET_REQ_FORCE
);
    input  wire       CLK_SYS;
    input  wire       RST_N;
    input  wire       POWER_ON_N;
    input  wire       CAUSE_PIN;
    input  wire       CAUSE_WD_TIMEOUT;
    input  wire       CAUSE_ILL_OP;
    input  wire       CAUSE_STOP_EXEC;
    input  wire       CAUSE_ENTER_BACKGROUND_INSTRUCTION_EXEC;
    input  wire       CAUSE_ILL_ADDR;
    input  wire       CAUSE_CLK_GEN;
    input  wire       CAUSE_LOW_VOLT;
    input  wire       STOP_PERMIT;
    input  wire       BACKGROUND_PERMIT;
    input  wire       WATCHDOG_ENABLE;
    input  wire       LOW_VOLTAGE_RESET_ENABLE;
    input  wire       LOW_VOLTAGE_STOP_ENABLE;
    input  wire       REG_SEL;
    input  wire       REG_WR;
    input  wire       REG_RD;
    input  wire       REG_DEBUG;
    input  wire [7:0] REG_WDATA;
    output reg  [7:0] REG_RDATA;
    output reg        WD_RESTART;
    output reg        RESET_REQ;
    output reg        RESET_REQ_FORCE;

    // ------------------------------------------------------------------
    // One-hot codes
    // ------------------------------------------------------------------
    // Phases of the reset tracker.
    localparam [2:0] PH_HELD  = 3'b001;
    localparam [2:0] PH_FIRST = 3'b010;
    localparam [2:0] PH_RUN   = 3'b100;
    // Kinds of reset, highest priority first.
    localparam [3:0] KIND_POWER_ON = 4'b0001;
    localparam [3:0] KIND_FORCED   = 4'b0010;
    localparam [3:0] KIND_LOW_VOLT = 4'b0100;
    localparam [3:0] KIND_OTHER    = 4'b1000;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    reg  [7:0] status_ff;
    reg        forced_ff;
    reg  [2:0] phase_ff;
    reg  [2:0] nxt_phase;
    reg  [7:0] nxt_rdata;
    reg        nxt_forced;
    wire [7:0] nxt_status;
    wire       nxt_restart;
    wire       nxt_reset_req;
    wire       nxt_force_req;
    wire       stop_illegal;
    wire       enter_background_instruction_illegal;
    wire       opcode_illegal;
    wire       wd_reset;
    wire       lv_reset;
    wire       force_hit;
    wire       status_wr;
    wire       status_rd;
    wire [3:0] kind;
    wire       kind_power_on;
    wire       kind_low_volt;
    wire       kind_other;
    wire       flag_power_on;
    wire       flag_pin;
    wire       flag_watchdog;
    wire       flag_ill_op;
    wire       flag_ill_addr;
    wire       flag_clk_gen;
    wire       flag_low_volt;

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    // True when the select points at the reset-cause status register.
    function is_status;
        input sel;
        begin
            is_status = (sel == `RCS_SEL_STATUS);
        end
    endfunction

    // True when the select points at the force-reset register.
    function is_force;
        input sel;
        begin
            is_force = (sel == `RCS_SEL_FORCE);
        end
    endfunction

    // Packs the seven cause flags into the register layout. Bit 0 is
    // not implemented and always reads zero.
    function [7:0] pack_flags;
        input por;
        input pin;
        input wdog;
        input bad_op;
        input bad_addr;
        input clk_req;
        input low_v;
        begin
            pack_flags                    = 8'h00;
            pack_flags[`RCS_BIT_POWER_ON] = por;
            pack_flags[`RCS_BIT_PIN]      = pin;
            pack_flags[`RCS_BIT_WATCHDOG] = wdog;
            pack_flags[`RCS_BIT_ILL_OP]   = bad_op;
            pack_flags[`RCS_BIT_ILL_ADDR] = bad_addr;
            pack_flags[`RCS_BIT_CLK_GEN]  = clk_req;
            pack_flags[`RCS_BIT_LOW_VOLT] = low_v;
        end
    endfunction

    // Sorts a reset into one kind. Power-on wins because the supply was
    // still ramping, so no other source can be trusted at that time.
    function [3:0] reset_kind;
        input por_n;
        input forced;
        input low_v;
        begin
            if (!por_n) begin
                reset_kind = KIND_POWER_ON;
            end else if (forced) begin
                reset_kind = KIND_FORCED;
            end else if (low_v) begin
                reset_kind = KIND_LOW_VOLT;
            end else begin
                reset_kind = KIND_OTHER;
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // Reset source qualification
    // ------------------------------------------------------------------
    assign stop_illegal   = CAUSE_STOP_EXEC & ~STOP_PERMIT;
    assign enter_background_instruction_illegal   = CAUSE_ENTER_BACKGROUND_INSTRUCTION_EXEC & ~BACKGROUND_PERMIT;
    assign opcode_illegal = CAUSE_ILL_OP | stop_illegal | enter_background_instruction_illegal;
    assign wd_reset       = CAUSE_WD_TIMEOUT & WATCHDOG_ENABLE;
    assign lv_reset       = CAUSE_LOW_VOLT & LOW_VOLTAGE_RESET_ENABLE
                            & LOW_VOLTAGE_STOP_ENABLE;

    // ------------------------------------------------------------------
    // Register access decode
    // ------------------------------------------------------------------
    assign status_wr = REG_WR & is_status(REG_SEL);
    assign status_rd = REG_RD & is_status(REG_SEL);
    // Only debug accesses may touch the force bit; zero does nothing.
    assign force_hit = REG_WR & REG_DEBUG & is_force(REG_SEL)
                       & REG_WDATA[`RCS_BIT_FORCE];

    // ------------------------------------------------------------------
    // Flag capture while reset is held
    // ------------------------------------------------------------------
    assign kind          = reset_kind(POWER_ON_N, forced_ff, lv_reset);
    assign kind_power_on = (kind == KIND_POWER_ON);
    assign kind_low_volt = (kind == KIND_LOW_VOLT);
    assign kind_other    = (kind == KIND_OTHER);
    assign flag_power_on = kind_power_on
                           | (kind_low_volt & status_ff[`RCS_BIT_POWER_ON]);
    assign flag_pin      = kind_other & CAUSE_PIN;
    assign flag_watchdog = kind_other & wd_reset;
    assign flag_ill_op   = kind_other & opcode_illegal;
    assign flag_ill_addr = kind_other & CAUSE_ILL_ADDR;
    assign flag_clk_gen  = kind_other & CAUSE_CLK_GEN;
    assign flag_low_volt = kind_power_on | kind_low_volt;
    assign nxt_status = pack_flags(flag_power_on, flag_pin, flag_watchdog,
                                   flag_ill_op, flag_ill_addr,
                                   flag_clk_gen, flag_low_volt);

    // ------------------------------------------------------------------
    // Next values of the pulse outputs
    // ------------------------------------------------------------------
    assign nxt_restart   = status_wr;
    assign nxt_reset_req = force_hit | wd_reset | lv_reset;
    assign nxt_force_req = force_hit;

    // ------------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------------
    always @* begin
        nxt_rdata = `RCS_FORCE_READ;
        if (status_rd) begin
            nxt_rdata = status_ff;
        end
    end

    // ------------------------------------------------------------------
    // Reset phase tracker
    // ------------------------------------------------------------------
    // The held phase marks the first clock after release, which is when
    // the forced marker must let go.
    always @* begin
        nxt_phase = phase_ff;
        case (phase_ff)
            PH_HELD: begin
                nxt_phase = PH_FIRST;
            end
            PH_FIRST: begin
                nxt_phase = PH_RUN;
            end
            PH_RUN: begin
                nxt_phase = PH_RUN;
            end
            default: begin
                nxt_phase = PH_RUN;
            end
        endcase
    end

    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            phase_ff <= PH_HELD;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    // ------------------------------------------------------------------
    // Forced-reset marker
    // ------------------------------------------------------------------
    // The forced marker survives the reset it causes, then clears once
    // the reset releases so later resets report their real cause.
    always @* begin
        nxt_forced = forced_ff;
        if (force_hit) begin
            nxt_forced = 1'b1;
        end else if (RST_N && (phase_ff == PH_HELD)) begin
            nxt_forced = 1'b0;
        end else if (!POWER_ON_N) begin
            nxt_forced = 1'b0;
        end
    end

    always @(posedge CLK_SYS) begin
        forced_ff <= nxt_forced;
    end

    // ------------------------------------------------------------------
    // Status register
    // ------------------------------------------------------------------
    // The flags are loaded only during reset, so no CPU write path exists.
    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            status_ff <= nxt_status;
        end
    end

    // ------------------------------------------------------------------
    // Read data register
    // ------------------------------------------------------------------
    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            REG_RDATA <= 8'h00;
        end else begin
            REG_RDATA <= nxt_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Watchdog restart pulse
    // ------------------------------------------------------------------
    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            WD_RESTART <= 1'b0;
        end else begin
            WD_RESTART <= nxt_restart;
        end
    end

    // ------------------------------------------------------------------
    // Reset request pulses
    // ------------------------------------------------------------------
    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            RESET_REQ <= 1'b0;
        end else begin
            RESET_REQ <= nxt_reset_req;
        end
    end

    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            RESET_REQ_FORCE <= 1'b0;
        end else begin
            RESET_REQ_FORCE <= nxt_force_req;
        end
    end

endmodule // rcs_reset_cause

// File: bench/rcs_props.sv
// Checker for the reset-cause block, bound to its top ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module rcs_props (
    input wire       CLK_SYS,
    input wire       RST_N,
    input wire       REG_SEL,
    input wire       REG_WR,
    input wire       REG_RD,
    input wire       REG_DEBUG,
    input wire [7:0] REG_WDATA,
    input wire [7:0] REG_RDATA,
    input wire       WD_RESTART,
    input wire       RESET_REQ,
    input wire       RESET_REQ_FORCE
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    wire st_wr = REG_WR && !REG_SEL;
    wire fc_wr = REG_WR && REG_SEL;
    wire dbg_fc = fc_wr && REG_DEBUG;
    AST_WD_RESTART: assert property (st_wr |=> WD_RESTART)
        else $error("status write gave no restart");
    AST_NO_STRAY_RESTART: assert property (!st_wr |=> !WD_RESTART)
        else $error("restart without status write");
    AST_FORCE_READ_ZERO: assert property (REG_RD && REG_SEL |=> REG_RDATA == 8'h00)
        else $error("force register read not zero");
    AST_STATUS_BIT0: assert property (REG_RD && !REG_SEL |=> !REG_RDATA[0])
        else $error("status bit 0 read as one");
    AST_USER_FORCE: assert property (fc_wr && !REG_DEBUG |=> !RESET_REQ_FORCE)
        else $error("program write forced reset");
    AST_DEBUG_FORCE: assert property (dbg_fc && REG_WDATA[0] |=> RESET_REQ && RESET_REQ_FORCE)
        else $error("debug write of one gave no reset");
    AST_DEBUG_ZERO: assert property (dbg_fc && !REG_WDATA[0] |=> !RESET_REQ_FORCE)
        else $error("debug write of zero forced reset");
    AST_FORCE_PAIR: assert property (RESET_REQ_FORCE |-> RESET_REQ)
        else $error("forced request without reset request");
    COV_FORCE: cover property (dbg_fc && REG_WDATA[0]);
    COV_STATUS_WR: cover property (st_wr);
    COV_STATUS_RD: cover property (REG_RD && !REG_SEL);
endmodule // rcs_props

// File: bench/rcs_dbg_host.sv
// Debug host model: writes the force-reset register over the debug path.
// Assumes the bench merges its strobe onto the register port.
`timescale 1ns/1ps
module rcs_dbg_host (
    input  wire       clk,
    output reg        dbg_wr,
    output reg  [7:0] dbg_wdata
);
    initial begin
        dbg_wr = 1'b0;
        dbg_wdata = 8'h00;
    end
    // Released data is inverted so a stale value is never mistaken.
    task send(input [7:0] d);
        begin
            @(posedge clk);
            dbg_wr <= 1'b1;
            dbg_wdata <= d;
            @(posedge clk);
            dbg_wr <= 1'b0;
            dbg_wdata <= ~d;
        end
    endtask
endmodule // rcs_dbg_host

// File: bench/rcs_reset_cause_bench.sv
// Bench for the reset-cause block; plays reset controller and CPU.
// Assumes the debug host model drives the debug path.
`timescale 1ns/1ps
module rcs_reset_cause_bench;
    reg CLK_SYS, RST_N, we, rd, wr, sel, sp, lve;
    reg [9:0] cause;
    reg [7:0] wd, v;
    reg [18:0] e;
    wire dwr, req, reqf, rwd;
    wire [7:0] dwd, rdata;
    integer mismatches, samples_checked, i;
    // Entries are enable, causes, expected flags; first is power-on.
    localparam [208:0] T = {19'h00202, 19'h02000, 19'h44444, 19'h40404,
        19'h60010, 19'h50010, 19'h41010, 19'h42020, 19'h44040, 19'h40282,
        19'h48082};
    rcs_dbg_host host (.clk(CLK_SYS), .dbg_wr(dwr), .dbg_wdata(dwd));
    rcs_reset_cause DUT (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
        .POWER_ON_N(~cause[7]), .CAUSE_PIN(cause[6]),
        .CAUSE_WD_TIMEOUT(cause[5]), .CAUSE_ILL_OP(cause[4]),
        .CAUSE_STOP_EXEC(cause[8]), .CAUSE_ENTER_BACKGROUND_INSTRUCTION_EXEC(cause[9]),
        .CAUSE_ILL_ADDR(cause[3]), .CAUSE_CLK_GEN(cause[2]),
        .CAUSE_LOW_VOLT(cause[1]), .STOP_PERMIT(sp),
        .BACKGROUND_PERMIT(1'b0), .WATCHDOG_ENABLE(we),
        .LOW_VOLTAGE_RESET_ENABLE(lve), .LOW_VOLTAGE_STOP_ENABLE(1'b1),
        .REG_SEL(sel | dwr), .REG_WR(wr | dwr), .REG_RD(rd),
        .REG_DEBUG(dwr), .REG_WDATA(dwr ? dwd : wd), .REG_RDATA(rdata),
        .WD_RESTART(rwd), .RESET_REQ(req), .RESET_REQ_FORCE(reqf));
    task chk(input string n, input [7:0] s, input [7:0] x);
        begin
            samples_checked = samples_checked + 1;
            if (s !== x) begin
                mismatches = mismatches + 1;
                $display("[FAIL] %0s expected %h seen %h", n, x, s);
            end
        end
    endtask
    task rst(input [9:0] c, input integer n);
        begin
            @(posedge CLK_SYS);
            RST_N <= 1'b0;
            cause <= c;
            repeat (n) @(posedge CLK_SYS);
            RST_N <= 1'b1;
            cause <= 10'h000;
        end
    endtask
    task acc(input w, input s, input [7:0] d);
        begin
            @(posedge CLK_SYS);
            wr <= w;
            rd <= ~w;
            sel <= s;
            wd <= d;
            @(posedge CLK_SYS);
            wr <= 1'b0;
            rd <= 1'b0;
            #1 v = rdata;
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", samples_checked, mismatches);
            if (mismatches == 0 && samples_checked > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    initial begin
        CLK_SYS = 1'b0;
        forever #50 CLK_SYS = ~CLK_SYS;
    end
    initial begin
        {RST_N, we, rd, wr, sel, wd} = 13'h0800;
        cause = 10'h080;
        sp = 1'b0;
        lve = 1'b1;
        mismatches = 0;
        samples_checked = 0;
        for (i = 0; i < 11; i = i + 1) begin
            e = T[i*19 +: 19];
            we <= e[18];
            rst(e[17:8], i == 0 ? 11 : 2);
            acc(1'b0, 1'b0, 8'h00);
            chk("status", v, e[7:0]);
        end
        acc(1'b1, 1'b0, 8'hFF);
        chk("restart", {7'h00, rwd}, 8'h01);
        acc(1'b0, 1'b0, 8'h00);
        chk("status", v, 8'h02);
        acc(1'b1, 1'b1, 8'h01);
        chk("user force", {6'h00, req, reqf}, 8'h00);
        acc(1'b0, 1'b1, 8'h00);
        chk("force read", v, 8'h00);
        host.send(8'h00);
        #1 chk("debug zero", {6'h00, req, reqf}, 8'h00);
        host.send(8'h01);
        #1 chk("debug one", {6'h00, req, reqf}, 8'h03);
        rst(10'h040, 2);
        acc(1'b0, 1'b0, 8'h00);
        chk("forced", v, 8'h00);
        sp <= 1'b1;
        rst(10'h108, 2);
        acc(1'b0, 1'b0, 8'h00);
        chk("permitted stop", v, 8'h08);
        lve <= 1'b0;
        rst(10'h002, 2);
        acc(1'b0, 1'b0, 8'h00);
        chk("low volt off", v, 8'h00);
        tally_and_finish;
    end
endmodule // rcs_reset_cause_bench
bind rcs_reset_cause rcs_props u_props (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
    .REG_SEL(REG_SEL), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_DEBUG(REG_DEBUG), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .WD_RESTART(WD_RESTART), .RESET_REQ(RESET_REQ),
    .RESET_REQ_FORCE(RESET_REQ_FORCE));
